// >>> design/dma_pkg.sv
// Purpose: Shared types of the two-channel DMA controller
// Assumes: Nothing beyond the register header
// Notes: Sizes and bandwidth follow the two-bit control fields
package dma_pkg;

    typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} size_e;

    typedef enum logic [1:0] {BW_25, BW_50, BW_75, BW_100} bw_e;

    typedef enum logic [1:0] {CH_IDLE, CH_READ, CH_WRITE, CH_FLY} chan_state_e;

endpackage

// >>> design/dma_regs.svh
// Purpose: Register offsets, field positions, reset values and pacing counts
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: Two channel register blocks, then the shared interrupt pair
//
// Notes on behaviour
// - Two channels, each with its own request, acknowledge and done line, run independently of each other.
// - Each channel is programmed to run either single-address (flyby) or dual-address transfers.
// - A single-address cycle drives only the source or destination address while the peripheral moves the data.
// - Single-address transfers start only on an external request from the peripheral.
// - Single-address transfers use 32-bit addresses with 8, 16 or 32-bit data.
// - A dual-address transfer is a read from the source followed by a write of that data to the destination.
// - A dual-address channel starts on either an internal request or an external request.
// - Dual-address transfers use 32-bit addresses with 8 or 16-bit data; 32-bit needs outside logic. The code runs 32-bit dual transfers itself.
// - Source and destination sizes are set independently and the data is packed or unpacked between them.
// - Each channel has 32-bit source, destination and count registers, the count in operands of the programmed size.
// - After each transfer each address advances by the operand size or stays put, as programmed.
// - External requests run in burst mode while the request is held, or one transfer per assertion in cycle-steal mode.
// - Internal requests take 25, 50, 75 or 100 percent of the bus, leaving the rest to the processor.
// - Each channel can raise a programmable interrupt on completion.
// - The controller requests the bus while the current cycle runs so its cycles follow back to back; the code does so only for the channel not on the bus.
`ifndef DMA_REGS_SVH
`define DMA_REGS_SVH

`define OFF_CTRL 5'h00
`define OFF_SRC 5'h04
`define OFF_DST 5'h08
`define OFF_CNT 5'h0C
`define OFF_STAT 5'h10
`define OFF_INT_STAT 8'h40
`define OFF_INT_MASK 8'h44

`define CTRL_START 0
`define CTRL_DUAL 1
`define CTRL_EXT 2
`define CTRL_BURST 3
`define CTRL_BW 4
`define CTRL_SSZ 6
`define CTRL_DSZ 8
`define CTRL_SINC 10
`define CTRL_DINC 11
`define CTRL_TODST 12
`define CTRL_RESET 13'h0000

`define STAT_BUSY 0
`define STAT_ZERO 1

`define GAP_25 2'h3
`define GAP_50 2'h1
`define GAP_75 2'h1
`define RUN_75 2'h2

`endif

// >>> design/dma_two_channel.sv
// Purpose: Two-channel DMA engine with APB registers and one bus master port
// Assumes: Arbiter grants m_gnt in pclk domain; peripheral requests are async
// Notes: Data sits in the low lanes of m_wdata and m_rdata
`timescale 1ns/1ns
`include "dma_regs.svh"
`default_nettype none

module dma_two_channel (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // System bus master
    output logic m_req,
    input wire logic m_gnt,
    output logic m_valid,
    output logic [31:0] m_addr,
    output logic m_write,
    output logic [1:0] m_size,
    output logic m_flyby,
    output logic [31:0] m_wdata,
    input wire logic [31:0] m_rdata,
    input wire logic m_ack,
    // Peripheral handshake
    input wire logic [1:0] xfer_req_n,
    output logic [1:0] xfer_ack,
    output logic [1:0] xfer_done,
    // Interrupt
    output logic irq
);

    function automatic logic [2:0] sz_bytes(input logic [1:0] s);
        case (s)
            2'h0: sz_bytes = 3'h1;
            2'h1: sz_bytes = 3'h2;
            default: sz_bytes = 3'h4;
        endcase
    endfunction

    function automatic logic reg_ok(input logic [7:0] a);
        reg_ok = (a[7:6] == 2'h0 && a[4:0] <= `OFF_STAT && a[1:0] == 2'h0)
            || a == `OFF_INT_STAT || a == `OFF_INT_MASK;
    endfunction

    // Channel context
    logic [12:0] ctrl_q [2];
    logic [31:0] src_q [2], dst_q [2], cnt_q [2], hold_q [2];
    logic [2:0] have_q [2];
    logic [1:0] thr_q [2], run_q [2];
    dma_pkg::chan_state_e st_q [2];
    logic [1:0] pend_q;
    // Request synchronisers
    logic [1:0] req_s1_q, req_s2_q, req_d3_q;
    // Bus master state
    logic bus_busy_q, bus_ch_q, last_q, m_req_q, m_valid_q, m_write_q, m_flyby_q;
    logic [31:0] m_addr_q, m_wdata_q;
    logic [1:0] m_size_q, xfer_ack_q, xfer_done_q;
    // APB and interrupt state
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q, irq_q;
    logic [1:0] int_stat_q, int_mask_q;
    // Per-channel decode
    logic [2:0] sb [2], db [2];
    logic [1:0] ext, gate, req_ok, elig, ack_ch, comp, fell;

    for (genvar g = 0; g < 2; g++) begin : g_ch
        assign sb[g] = sz_bytes(ctrl_q[g][`CTRL_SSZ +: 2]);
        assign db[g] = sz_bytes(ctrl_q[g][`CTRL_DSZ +: 2]);
        // Flyby is always external; dual chooses
        assign ext[g] = !ctrl_q[g][`CTRL_DUAL] || ctrl_q[g][`CTRL_EXT];
        assign gate[g] = st_q[g] == dma_pkg::CH_FLY
            || (st_q[g] == dma_pkg::CH_READ && have_q[g] == 3'h0);
        assign req_ok[g] = !ext[g] || !gate[g]
            || (ctrl_q[g][`CTRL_BURST] ? !req_s2_q[g] : pend_q[g]);
        assign elig[g] = st_q[g] != dma_pkg::CH_IDLE && thr_q[g] == 2'h0 && req_ok[g]
            && !(bus_busy_q && bus_ch_q == 1'(g));
        assign ack_ch[g] = m_ack && bus_busy_q && bus_ch_q == 1'(g);
        assign comp[g] = ack_ch[g] && cnt_q[g] == 32'h1
            && (st_q[g] == dma_pkg::CH_WRITE || st_q[g] == dma_pkg::CH_FLY);
        assign fell[g] = req_d3_q[g] && !req_s2_q[g];
    end
    // Issue selection, alternating on contention
    logic pick, issue, iss_todst, iss_wr;
    dma_pkg::chan_state_e pst;
    assign pick = (elig[0] && elig[1]) ? !last_q : elig[1];
    assign issue = elig != 2'h0 && m_gnt && (!bus_busy_q || m_ack);
    assign pst = st_q[pick];
    assign iss_todst = pst == dma_pkg::CH_WRITE || (pst == dma_pkg::CH_FLY && ctrl_q[pick][`CTRL_TODST]);
    assign iss_wr = iss_todst;
    // APB strobes
    logic wr_en;
    assign wr_en = psel && penable && pwrite && pready_q;
    // Request synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_s1_q <= 2'h3;
            req_s2_q <= 2'h3;
            req_d3_q <= 2'h3;
        end else begin
            req_s1_q <= xfer_req_n;
            req_s2_q <= req_s1_q;
            req_d3_q <= req_s2_q;
        end
    end
    // Bus master cycle control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_busy_q <= 1'b0;
            bus_ch_q <= 1'b0;
            last_q <= 1'b1;
            m_req_q <= 1'b0;
            m_valid_q <= 1'b0;
            m_addr_q <= 32'h0;
            m_write_q <= 1'b0;
            m_size_q <= 2'h0;
            m_flyby_q <= 1'b0;
            m_wdata_q <= 32'h0;
            xfer_ack_q <= 2'h0;
            xfer_done_q <= 2'h0;
        end else begin
            // Held while a channel not on the bus has work waiting, even during a running cycle
            m_req_q <= elig != 2'h0;
            if (m_ack && bus_busy_q) begin
                bus_busy_q <= 1'b0;
                m_valid_q <= 1'b0;
                xfer_ack_q <= 2'h0;
                xfer_done_q <= 2'h0;
            end
            if (issue) begin
                bus_busy_q <= 1'b1;
                bus_ch_q <= pick;
                last_q <= pick;
                m_valid_q <= 1'b1;
                // One address only in flyby
                m_addr_q <= iss_todst ? dst_q[pick] : src_q[pick];
                m_write_q <= iss_wr;
                m_size_q <= pst == dma_pkg::CH_WRITE ? ctrl_q[pick][`CTRL_DSZ +: 2]
                    : ctrl_q[pick][`CTRL_SSZ +: 2];
                m_flyby_q <= pst == dma_pkg::CH_FLY;
                m_wdata_q <= hold_q[pick];
                xfer_ack_q <= 2'h0;
                xfer_ack_q[pick] <= ext[pick];
                xfer_done_q <= 2'h0;
                xfer_done_q[pick] <= cnt_q[pick] == 32'h1
                    && (pst == dma_pkg::CH_WRITE || pst == dma_pkg::CH_FLY);
            end
        end
    end
    // Channel engines and register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 2; i++) begin
                ctrl_q[i] <= `CTRL_RESET;
                src_q[i] <= 32'h0;
                dst_q[i] <= 32'h0;
                cnt_q[i] <= 32'h0;
                hold_q[i] <= 32'h0;
                have_q[i] <= 3'h0;
                thr_q[i] <= 2'h0;
                run_q[i] <= 2'h0;
                st_q[i] <= dma_pkg::CH_IDLE;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (thr_q[i] != 2'h0) begin
                    thr_q[i] <= thr_q[i] - 2'h1;
                end
                if (wr_en && paddr[7:6] == 2'h0 && paddr[5] == 1'(i) && st_q[i] == dma_pkg::CH_IDLE) begin
                    case (paddr[4:0])
                        `OFF_CTRL: begin
                            ctrl_q[i] <= {pwdata[12:1], 1'b0};
                            if (pwdata[`CTRL_START] && cnt_q[i] != 32'h0) begin
                                st_q[i] <= pwdata[`CTRL_DUAL] ? dma_pkg::CH_READ : dma_pkg::CH_FLY;
                                have_q[i] <= 3'h0;
                                hold_q[i] <= 32'h0;
                                run_q[i] <= 2'h0;
                            end
                        end
                        `OFF_SRC: src_q[i] <= pwdata;
                        `OFF_DST: dst_q[i] <= pwdata;
                        `OFF_CNT: cnt_q[i] <= pwdata;
                        default: ;
                    endcase
                end
                if (ack_ch[i]) begin
                    case (st_q[i])
                        dma_pkg::CH_READ: begin
                            // Pack source reads into the holding word
                            hold_q[i] <= hold_q[i] | ((sb[i] == 3'h1 ? {24'h0, m_rdata[7:0]}
                                : sb[i] == 3'h2 ? {16'h0, m_rdata[15:0]} : m_rdata)
                                << {have_q[i], 3'h0});
                            have_q[i] <= have_q[i] + sb[i];
                            if (ctrl_q[i][`CTRL_SINC]) begin
                                src_q[i] <= src_q[i] + {29'h0, sb[i]};
                            end
                            st_q[i] <= (have_q[i] + sb[i] >= db[i]) ? dma_pkg::CH_WRITE : dma_pkg::CH_READ;
                        end
                        dma_pkg::CH_WRITE: begin
                            // Unpack: keep the rest for following writes
                            hold_q[i] <= hold_q[i] >> {db[i], 3'h0};
                            have_q[i] <= have_q[i] - db[i];
                            if (ctrl_q[i][`CTRL_DINC]) begin
                                dst_q[i] <= dst_q[i] + {29'h0, db[i]};
                            end
                            cnt_q[i] <= cnt_q[i] - 32'h1;
                            if (cnt_q[i] == 32'h1) begin
                                st_q[i] <= dma_pkg::CH_IDLE;
                            end else begin
                                st_q[i] <= (have_q[i] - db[i] >= db[i]) ? dma_pkg::CH_WRITE : dma_pkg::CH_READ;
                            end
                        end
                        dma_pkg::CH_FLY: begin
                            if (ctrl_q[i][`CTRL_TODST] && ctrl_q[i][`CTRL_DINC]) begin
                                dst_q[i] <= dst_q[i] + {29'h0, sb[i]};
                            end
                            if (!ctrl_q[i][`CTRL_TODST] && ctrl_q[i][`CTRL_SINC]) begin
                                src_q[i] <= src_q[i] + {29'h0, sb[i]};
                            end
                            cnt_q[i] <= cnt_q[i] - 32'h1;
                            if (cnt_q[i] == 32'h1) begin
                                st_q[i] <= dma_pkg::CH_IDLE;
                            end
                        end
                        default: ;
                    endcase
                    // Bandwidth pacing of internal requests
                    if (!ext[i]) begin
                        case (dma_pkg::bw_e'(ctrl_q[i][`CTRL_BW +: 2]))
                            dma_pkg::BW_25: thr_q[i] <= `GAP_25;
                            dma_pkg::BW_50: thr_q[i] <= `GAP_50;
                            dma_pkg::BW_75: begin
                                if (run_q[i] == `RUN_75) begin
                                    thr_q[i] <= `GAP_75;
                                    run_q[i] <= 2'h0;
                                end else begin
                                    run_q[i] <= run_q[i] + 2'h1;
                                end
                            end
                            dma_pkg::BW_100: ;
                        endcase
                    end
                end
            end
        end
    end
    // Cycle-steal pending request, set wins over use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (issue && pick == 1'(i) && gate[i]) begin
                    pend_q[i] <= 1'b0;
                end
                if (fell[i]) begin
                    pend_q[i] <= 1'b1;
                end
            end
        end
    end
    // Read mux
    logic [31:0] rd_val;
    always_comb begin
        rd_val = 32'h0;
        if (paddr == `OFF_INT_STAT) begin
            rd_val = {30'h0, int_stat_q};
        end else if (paddr == `OFF_INT_MASK) begin
            rd_val = {30'h0, int_mask_q};
        end else if (paddr[7:6] == 2'h0) begin
            case (paddr[4:0])
                `OFF_CTRL: rd_val = {19'h0, ctrl_q[paddr[5]]};
                `OFF_SRC: rd_val = src_q[paddr[5]];
                `OFF_DST: rd_val = dst_q[paddr[5]];
                `OFF_CNT: rd_val = cnt_q[paddr[5]];
                `OFF_STAT: rd_val = {30'h0, cnt_q[paddr[5]] == 32'h0,
                    st_q[paddr[5]] != dma_pkg::CH_IDLE};
                default: rd_val = 32'h0;
            endcase
        end
    end
    // APB answer, ready in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end else if (psel && !penable) begin
            pready_q <= 1'b1;
            pslverr_q <= !reg_ok(paddr);
            prdata_q <= pwrite ? 32'h0 : rd_val;
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end
    // Completion flags, mask and interrupt line
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat_q <= 2'h0;
            int_mask_q <= 2'h0;
            irq_q <= 1'b0;
        end else begin
            int_stat_q <= (int_stat_q & ~((wr_en && paddr == `OFF_INT_STAT) ? pwdata[1:0] : 2'h0))
                | comp;
            if (wr_en && paddr == `OFF_INT_MASK) begin
                int_mask_q <= pwdata[1:0];
            end
            irq_q <= (int_stat_q & int_mask_q) != 2'h0;
        end
    end
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign m_req = m_req_q;
    assign m_valid = m_valid_q;
    assign m_addr = m_addr_q;
    assign m_write = m_write_q;
    assign m_size = m_size_q;
    assign m_flyby = m_flyby_q;
    assign m_wdata = m_wdata_q;
    assign xfer_ack = xfer_ack_q;
    assign xfer_done = xfer_done_q;
    assign irq = irq_q;
    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_fly_single;
        m_valid_q && m_flyby_q |-> !ctrl_q[bus_ch_q][`CTRL_DUAL]
            && m_write_q == ctrl_q[bus_ch_q][`CTRL_TODST];
    endproperty
    a_fly_single: assert property (p_fly_single) else $error("flyby cycle mode or direction wrong");

    property p_fly_ext;
        m_valid_q && m_flyby_q |-> xfer_ack_q[bus_ch_q];
    endproperty
    a_fly_ext: assert property (p_fly_ext) else $error("flyby cycle without peripheral acknowledge");

    for (genvar g = 0; g < 2; g++) begin : g_chk
        sequence s_last_ack;
            ack_ch[g] && xfer_done_q[g];
        endsequence
        sequence s_pack_full;
            ack_ch[g] && st_q[g] == dma_pkg::CH_READ && have_q[g] + sb[g] >= db[g];
        endsequence

        property p_ack_in_cycle;
            xfer_ack_q[g] |-> m_valid_q && bus_ch_q == 1'(g);
        endproperty
        a_ack_in_cycle: assert property (p_ack_in_cycle) else $error("acknowledge outside own cycle");

        property p_done_last;
            xfer_done_q[g] |-> m_valid_q && bus_ch_q == 1'(g) && cnt_q[g] == 32'h1;
        endproperty
        a_done_last: assert property (p_done_last) else $error("done not on final transfer");

        property p_complete;
            s_last_ack |=> int_stat_q[g] && st_q[g] == dma_pkg::CH_IDLE && cnt_q[g] == 32'h0 ##1 !xfer_done_q[g];
        endproperty
        a_complete: assert property (p_complete) else $error("completion not flagged");

        property p_read_then_write;
            s_pack_full |=> st_q[g] == dma_pkg::CH_WRITE;
        endproperty
        a_read_then_write: assert property (p_read_then_write) else $error("no write after full read");

        property p_gap25;
            ack_ch[g] && !ext[g] && ctrl_q[g][`CTRL_BW +: 2] == 2'h0
                |=> !(issue && pick == 1'(g)) [*3];
        endproperty
        a_gap25: assert property (p_gap25) else $error("quarter bandwidth gap too short");

        property p_steal;
            issue && pick == 1'(g) && ext[g] && gate[g] && !ctrl_q[g][`CTRL_BURST] |-> pend_q[g];
        endproperty
        a_steal: assert property (p_steal) else $error("steal transfer without request");

        property p_irq;
            int_stat_q[g] && int_mask_q[g] |=> irq_q;
        endproperty
        a_irq: assert property (p_irq) else $error("unmasked completion not raised");
    end

endmodule

`default_nettype wire

// >>> verif/bus_mem_model.sv
// Purpose: Memory and arbiter stand-in on the DMA bus master side
// Assumes: One clock; read data is derived from the address
// Notes: Counts bus cycles and handshake flags for the bench
`timescale 1ns/1ns
`default_nettype none

module bus_mem_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bus slave side
    input wire logic m_req,
    input wire logic m_valid,
    input wire logic [31:0] m_addr,
    input wire logic m_write,
    input wire logic [31:0] m_wdata,
    output logic m_gnt,
    output logic [31:0] m_rdata,
    output logic m_ack,
    // Control and observation
    input wire logic slow,
    input wire logic [1:0] xfer_ack,
    input wire logic [1:0] xfer_done,
    output logic [31:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [7:0] n_wr,
    output logic [7:0] n_rd,
    output logic [7:0] n_ack,
    output logic [7:0] n_done
);
    logic [1:0] wait_q;
    logic [31:0] pat;

    assign pat = m_addr ^ 32'h5A5A5A5A;
    // Grant whenever asked
    assign m_gnt = m_req;
    // Data valid only at the ack edge, inverted otherwise
    assign m_rdata = m_ack ? pat : ~pat;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            m_ack <= 1'b0;
            wait_q <= 2'h0;
            n_wr <= 8'h00;
            n_rd <= 8'h00;
            n_ack <= 8'h00;
            n_done <= 8'h00;
            wr_addr <= 32'h0;
            wr_data <= 32'h0;
        end else begin
            m_ack <= 1'b0;
            if (m_valid && !m_ack) begin
                if (wait_q >= {slow, slow}) begin
                    m_ack <= 1'b1;
                    wait_q <= 2'h0;
                end else begin
                    wait_q <= wait_q + 2'h1;
                end
            end
            if (m_valid && m_ack) begin
                if (m_write) begin
                    n_wr <= n_wr + 8'h01;
                    wr_addr <= m_addr;
                    wr_data <= m_wdata;
                end else begin
                    n_rd <= n_rd + 8'h01;
                end
                if (|xfer_ack) begin
                    n_ack <= n_ack + 8'h01;
                end
                if (|xfer_done) begin
                    n_done <= n_done + 8'h01;
                end
            end
        end
    end
endmodule

`default_nettype wire

// >>> verif/two_channel_dma_controller_tb_top.sv
// Purpose: Self-checking bench for the two-channel DMA controller
// Assumes: APB with zero wait states; memory model answers the bus
// Notes: Dual packing run, flyby steal run, register and interrupt checks
`timescale 1ns/1ns
`include "dma_regs.svh"
`default_nettype none
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin num_errors++; \
    $display("Error %s exp %h got %h", nm, ex, gt); end end

module two_channel_dma_controller_tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic slow = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [1:0] xfer_req_n = 2'h3;
    wire logic [31:0] prdata, m_addr, m_wdata, m_rdata, wr_addr, wr_data;
    wire logic pready, pslverr, m_req, m_gnt, m_valid, m_write, m_flyby, m_ack, irq;
    wire logic [1:0] m_size, xfer_ack, xfer_done;
    wire logic [7:0] n_wr, n_rd, n_ack, n_done;
    int num_errors = 0;
    int n_checks = 0;
    int cyc = 0;

    dma_two_channel i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .m_req(m_req), .m_gnt(m_gnt), .m_valid(m_valid), .m_addr(m_addr),
        .m_write(m_write), .m_size(m_size), .m_flyby(m_flyby), .m_wdata(m_wdata),
        .m_rdata(m_rdata), .m_ack(m_ack), .xfer_req_n(xfer_req_n), .xfer_ack(xfer_ack),
        .xfer_done(xfer_done), .irq(irq));
    bus_mem_model i_mem (.pclk(pclk), .presetn(presetn), .m_req(m_req), .m_valid(m_valid),
        .m_addr(m_addr), .m_write(m_write), .m_wdata(m_wdata), .m_gnt(m_gnt),
        .m_rdata(m_rdata), .m_ack(m_ack), .slow(slow), .xfer_ack(xfer_ack),
        .xfer_done(xfer_done), .wr_addr(wr_addr), .wr_data(wr_data), .n_wr(n_wr),
        .n_rd(n_rd), .n_ack(n_ack), .n_done(n_done));

    initial forever #2 pclk = ~pclk;

    task automatic end_of_test();
        if (num_errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            end_of_test();
        end
    end

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask

    task automatic wait_idle(input logic [7:0] base);
        logic [31:0] s;
        do rd(base + `OFF_STAT, s); while (s[`STAT_BUSY] !== 1'b0);
    endtask

    task automatic pulse();
        xfer_req_n[1] <= 1'b0;
        repeat (4) @(posedge pclk);
        xfer_req_n[1] <= 1'b1;
        repeat (20) @(posedge pclk);
    endtask

    task automatic t_regs();
        logic [31:0] r;
        logic e;
        rd(`OFF_CTRL, r);
        `CHK("ctrl0", 32'h0, r)
        rd(8'h20 + `OFF_STAT, r);
        `CHK("stat1", 32'h2, r)
        rd(`OFF_INT_STAT, r);
        `CHK("int_stat", 32'h0, r)
        apb(1'b0, 8'h80, 32'h0, r, e);
        `CHK("unmapped", 1'b1, e)
        wr(`OFF_SRC, 32'hFFFFFFFC);
        rd(`OFF_SRC, r);
        `CHK("src0", 32'hFFFFFFFC, r)
    endtask

    task automatic t_dual();
        logic [31:0] r;
        slow <= 1'b1;
        wr(`OFF_SRC, 32'h100);
        wr(`OFF_DST, 32'h200);
        wr(`OFF_CNT, 32'h2);
        wr(`OFF_INT_MASK, 32'h1);
        // Dual, byte to word, both increment, full bandwidth
        wr(`OFF_CTRL, 32'hD33);
        wait_idle(8'h00);
        `CHK("reads", 8'h04, n_rd)
        `CHK("writes", 8'h02, n_wr)
        `CHK("wdata", 16'h5958, wr_data[15:0])
        `CHK("waddr", 32'h202, wr_addr)
        `CHK("acks", 8'h00, n_ack)
        `CHK("dones", 8'h01, n_done)
        `CHK("dual_sz", 2'h1, m_size)
        `CHK("dual_fly", 1'b0, m_flyby)
        rd(`OFF_SRC, r);
        `CHK("src", 32'h104, r)
        rd(`OFF_CNT, r);
        `CHK("cnt", 32'h0, r)
        rd(`OFF_STAT, r);
        `CHK("stat", 32'h2, r)
        rd(`OFF_INT_STAT, r);
        `CHK("int_set", 32'h1, r)
        `CHK("irq_on", 1'b1, irq)
        wr(`OFF_INT_STAT, 32'h1);
        rd(`OFF_INT_STAT, r);
        `CHK("int_clr", 32'h0, r)
        `CHK("irq_off", 1'b0, irq)
        slow <= 1'b0;
    endtask

    task automatic t_fly();
        logic [31:0] r;
        wr(8'h20 + `OFF_DST, 32'h300);
        wr(8'h20 + `OFF_CNT, 32'h2);
        // Flyby to destination, long, fixed address, steal
        wr(8'h20 + `OFF_CTRL, 32'h1285);
        repeat (20) @(posedge pclk);
        `CHK("no_req", 8'h02, n_wr)
        pulse();
        `CHK("steal1", 8'h03, n_wr)
        `CHK("ack1", 8'h01, n_ack)
        pulse();
        wait_idle(8'h20);
        `CHK("steal2", 8'h04, n_wr)
        `CHK("fly_addr", 32'h300, wr_addr)
        `CHK("fly_done", 8'h02, n_done)
        `CHK("fly_sz", 2'h2, m_size)
        `CHK("fly_mode", 1'b1, m_flyby)
        `CHK("fly_wr", 1'b1, m_write)
        `CHK("req_idle", 1'b0, m_req)
        rd(`OFF_INT_STAT, r);
        `CHK("int1", 32'h2, r)
        `CHK("irq_mask", 1'b0, irq)
    endtask

    task automatic t_pace();
        logic [31:0] r;
        wr(`OFF_CNT, 32'h2);
        // Dual, byte to byte, fixed addresses, quarter bandwidth
        wr(`OFF_CTRL, 32'h003);
        wait_idle(8'h00);
        `CHK("pace_rd", 8'h06, n_rd)
        `CHK("pace_wr", 8'h06, n_wr)
        `CHK("pace_data", 8'h5E, wr_data[7:0])
        `CHK("pace_addr", 32'h204, wr_addr)
        rd(`OFF_INT_STAT, r);
        `CHK("int_both", 32'h3, r)
        `CHK("irq_pace", 1'b1, irq)
    endtask

    task automatic t_burst();
        logic [31:0] r;
        wr(8'h20 + `OFF_SRC, 32'h400);
        wr(8'h20 + `OFF_CNT, 32'h3);
        // Flyby from source, byte, incrementing, burst
        wr(8'h20 + `OFF_CTRL, 32'h40D);
        xfer_req_n[1] <= 1'b0;
        wait_idle(8'h20);
        xfer_req_n[1] <= 1'b1;
        `CHK("burst_rd", 8'h09, n_rd)
        `CHK("burst_ack", 8'h05, n_ack)
        `CHK("burst_done", 8'h04, n_done)
        `CHK("burst_wr", 1'b0, m_write)
        rd(8'h20 + `OFF_SRC, r);
        `CHK("burst_src", 32'h403, r)
    endtask

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_dual();
        t_fly();
        t_pace();
        t_burst();
        end_of_test();
    end
endmodule

`default_nettype wire
